// ===== design/dprc_port_ctrl.sv
// controller driving one port of a dual-port ram with mailbox and semaphores
// assumes the ram pins are asynchronous; wire tristate is resolved outside
//
// What this block does
// - right port reads 1fff to clear its flag; device deasserts it.
// - in slave mode hold busy high normally, low to block writes.
// - depth expansion: external and of busy outputs.
// - width expansion: one master, others take its busy as inhibit.
// - hold address and select until busy settles before write pulse.
`timescale 1ns/1ns
`include "dprc_defs.svh"
module dprc_port_ctrl
import dprc_pkg::*;
#(
    parameter bit PORT_IS_LEFT = 1'b1
)
(
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    // user side
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire logic [1:0]                req_op,
    input  wire logic [`DPRC_ADDR_W-1:0]   req_addr,
    input  wire logic [`DPRC_DATA_W-1:0]   req_wdata,
    output logic                           resp_valid,
    output logic [`DPRC_DATA_W-1:0]        resp_rdata,
    output logic                           resp_collided,
    output logic                           init_done,
    output logic                           mailbox_irq,
    input  wire logic                      write_inhibit,
    input  wire logic                      master_mode,
    // ram pins
    output logic [`DPRC_ADDR_W-1:0]        mem_addr,
    output logic                           mem_select_n,
    output logic                           semaphore_select_n,
    output logic                           rw_n,
    output logic                           oe_n,
    output logic [`DPRC_DATA_W-1:0]        data_out,
    output logic                           data_oe,
    input  wire logic [`DPRC_DATA_W-1:0]   data_in,
    input  wire logic                      busy_in_n,
    output logic                           busy_out_n,
    output logic                           busy_oe,
    input  wire logic                      port_mailbox_irq_n
);
    localparam logic [`DPRC_ADDR_W-1:0] MBOX_OWN =
        PORT_IS_LEFT ? `DPRC_MBOX_LEFT : `DPRC_MBOX_RIGHT;

    function automatic logic is_write(input logic [1:0] op);
        is_write = (op == DPRC_OP_WR) || (op == DPRC_OP_SEM_WR);
    endfunction : is_write

    function automatic logic is_sem(input logic [1:0] op);
        is_sem = (op == DPRC_OP_SEM_RD) || (op == DPRC_OP_SEM_WR);
    endfunction : is_sem

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [`DPRC_DATA_W-1:0] din_s1_r, din_s2_r;
    logic [2:0]              ctl_s1_r, ctl_s2_r;
    logic                    busy_s, irq_s, mode_s;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
            // mode reads as master until known: never drive busy blind
            ctl_s1_r <= 3'h7;
            ctl_s2_r <= 3'h7;
        end
        else
        begin
            din_s1_r <= data_in;
            din_s2_r <= din_s1_r;
            ctl_s1_r <= {master_mode, port_mailbox_irq_n, busy_in_n};
            ctl_s2_r <= ctl_s1_r;
        end
    end

    // deep arrays present the and of all master busy outputs here
    assign busy_s = ctl_s2_r[0];
    assign irq_s  = ctl_s2_r[1];
    assign mode_s = ctl_s2_r[2];

    // --------------------------------------------------------------
    // access sequencer
    // --------------------------------------------------------------
    dprc_state_t             state_r, state_nxt;
    logic [1:0]              op_r, op_nxt;
    logic [`DPRC_ADDR_W-1:0] addr_r, addr_nxt;
    logic [`DPRC_DATA_W-1:0] dout_r, dout_nxt, rdata_r, rdata_nxt;
    logic ce_n_r, ce_n_nxt, sem_n_r, sem_n_nxt, rw_n_r, rw_n_nxt;
    logic oe_n_r, oe_n_nxt, doe_r, doe_nxt, rv_r, rv_nxt;
    logic coll_r, coll_nxt, rdy_r, rdy_nxt;
    logic bsy_o_r, bsy_o_nxt, bsy_oe_r, bsy_oe_nxt, irq_r, irq_nxt;
    logic [3:0] init_r, init_nxt;
    logic       done_r, done_nxt;
    logic       tload;
    logic [3:0] tval;
    logic       tdone;
    logic       init_busy;

    dprc_timer u_timer
    (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .load     (tload),
        .load_val (tval),
        .done     (tdone)
    );

    // init: release all semaphores, then read own mailbox
    assign init_busy = (init_r <= `DPRC_SEM_COUNT);

    always_comb
    begin
        state_nxt  = state_r;
        op_nxt     = op_r;
        addr_nxt   = addr_r;
        dout_nxt   = dout_r;
        rdata_nxt  = rdata_r;
        ce_n_nxt   = ce_n_r;
        sem_n_nxt  = sem_n_r;
        rw_n_nxt   = rw_n_r;
        oe_n_nxt   = oe_n_r;
        doe_nxt    = doe_r;
        rv_nxt     = 1'b0;
        coll_nxt   = coll_r;
        init_nxt   = init_r;
        done_nxt   = !init_busy;
        rdy_nxt    = 1'b0;
        tload      = 1'b0;
        tval       = 4'h1;
        // slave mode: host owns the busy pin as write inhibit
        bsy_oe_nxt = !mode_s;
        bsy_o_nxt  = !write_inhibit;
        irq_nxt    = !irq_s;
        unique case (state_r)
            DPRC_ST_IDLE:
            begin
                if (init_busy || (req_valid && rdy_r))
                begin
                    if (init_busy)
                    begin
                        op_nxt   = (init_r == `DPRC_SEM_COUNT) ?
                                   DPRC_OP_RD : DPRC_OP_SEM_WR;
                        addr_nxt = (init_r == `DPRC_SEM_COUNT) ? MBOX_OWN :
                                   {10'h000, init_r[2:0]};
                        dout_nxt = 8'hff;
                    end
                    else
                    begin
                        op_nxt   = req_op;
                        addr_nxt = is_sem(req_op) ?
                                   {10'h000, req_addr[2:0]} : req_addr;
                        dout_nxt = is_sem(req_op) ?
                                   {8{req_wdata[0]}} : req_wdata;
                    end
                    ce_n_nxt  = init_busy ? (init_r != `DPRC_SEM_COUNT) :
                                is_sem(req_op);
                    sem_n_nxt = !ce_n_nxt;
                    coll_nxt  = 1'b0;
                    tload     = 1'b1;
                    // address and select settle before any strobe
                    tval      = 4'(`DPRC_BSY_CYC);
                    state_nxt = DPRC_ST_SETUP;
                end
                else
                    rdy_nxt = !init_busy;
            end
            DPRC_ST_SETUP:
            begin
                if (tdone)
                begin
                    tload = 1'b1;
                    // semaphores never collide, so busy is ignored there
                    if (mode_s && !busy_s && !is_sem(op_r))
                    begin
                        coll_nxt = 1'b1;
                        tval     = 4'h1;
                    end
                    else
                    begin
                        rw_n_nxt  = !is_write(op_r);
                        oe_n_nxt  = is_write(op_r);
                        doe_nxt   = is_write(op_r);
                        tval      = 4'(`DPRC_ACC_CYC);
                        state_nxt = DPRC_ST_STROBE;
                    end
                end
            end
            DPRC_ST_STROBE:
            begin
                if (tdone)
                begin
                    if (op_r == DPRC_OP_SEM_RD)
                        rdata_nxt = {8{din_s2_r[0]}};
                    else if (op_r == DPRC_OP_RD)
                        rdata_nxt = din_s2_r;
                    rw_n_nxt  = 1'b1;
                    // drop oe and select so the next semaphore read relatches
                    oe_n_nxt  = 1'b1;
                    ce_n_nxt  = 1'b1;
                    sem_n_nxt = 1'b1;
                    tload     = 1'b1;
                    tval      = 4'(`DPRC_REC_CYC);
                    state_nxt = DPRC_ST_RECOV;
                end
            end
            DPRC_ST_RECOV:
            begin
                if (tdone)
                begin
                    doe_nxt = 1'b0;
                    if (init_busy)
                        init_nxt = init_r + 4'h1;
                    else
                        rv_nxt = 1'b1;
                    state_nxt = DPRC_ST_IDLE;
                end
            end
            default:
                state_nxt = DPRC_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r  <= DPRC_ST_IDLE;
            op_r     <= DPRC_OP_RD;
            addr_r   <= 13'h0000;
            dout_r   <= 8'h00;
            rdata_r  <= 8'h00;
            ce_n_r   <= 1'b1;
            sem_n_r  <= 1'b1;
            rw_n_r   <= 1'b1;
            oe_n_r   <= 1'b1;
            doe_r    <= 1'b0;
            rv_r     <= 1'b0;
            coll_r   <= 1'b0;
            init_r   <= 4'h0;
            done_r   <= 1'b0;
            rdy_r    <= 1'b0;
            bsy_o_r  <= 1'b1;
            bsy_oe_r <= 1'b0;
            irq_r    <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            op_r     <= op_nxt;
            addr_r   <= addr_nxt;
            dout_r   <= dout_nxt;
            rdata_r  <= rdata_nxt;
            ce_n_r   <= ce_n_nxt;
            sem_n_r  <= sem_n_nxt;
            rw_n_r   <= rw_n_nxt;
            oe_n_r   <= oe_n_nxt;
            doe_r    <= doe_nxt;
            rv_r     <= rv_nxt;
            coll_r   <= coll_nxt;
            init_r   <= init_nxt;
            done_r   <= done_nxt;
            rdy_r    <= rdy_nxt;
            bsy_o_r  <= bsy_o_nxt;
            bsy_oe_r <= bsy_oe_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign req_ready          = rdy_r;
    assign resp_valid         = rv_r;
    assign resp_rdata         = rdata_r;
    assign resp_collided      = coll_r;
    assign init_done          = done_r;
    assign mailbox_irq        = irq_r;
    assign mem_addr           = addr_r;
    assign mem_select_n       = ce_n_r;
    assign semaphore_select_n = sem_n_r;
    assign rw_n               = rw_n_r;
    assign oe_n               = oe_n_r;
    assign data_out           = dout_r;
    assign data_oe            = doe_r;
    assign busy_out_n         = bsy_o_r;
    assign busy_oe            = bsy_oe_r;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_STROBE_AFTER_SETTLE:
        assert property ($fell(rw_n) |-> $past(!ce_n_r || !sem_n_r, 4))
        else $error("write strobe before select settled");
    AST_SEM_ADDR_LOW:
        assert property (!sem_n_r |-> addr_r[12:3] == 10'h000)
        else $error("semaphore access with high address bits set");
    AST_ONE_SELECT:
        assert property (!(!ce_n_r && !sem_n_r))
        else $error("memory and semaphore selected together");
    AST_SLAVE_DRIVES_BUSY:
        assert property (!mode_s ##1 !mode_s |-> busy_oe)
        else $error("slave mode busy pin not driven");
    AST_MASTER_RELEASES_BUSY:
        assert property (mode_s ##1 mode_s |-> !busy_oe)
        else $error("host drives busy pin against a master");
    AST_NO_RESP_BEFORE_INIT:
        assert property (init_busy |-> !rv_r && !rdy_r)
        else $error("user traffic before flag initialisation");
    AST_SELECT_DROPS_AFTER_READ:
        assert property ($rose(oe_n) |-> ce_n_r && sem_n_r)
        else $error("select held after read strobe");

    COV_INIT_DONE:   cover property ($fell(init_busy));
    COV_COLLISION:   cover property ($rose(coll_r));
    COV_SEM_READ:    cover property (rv_r && op_r == DPRC_OP_SEM_RD);
    COV_MBOX_IRQ:    cover property ($rose(irq_r));

endmodule : dprc_port_ctrl

// ===== design/dprc_timer.sv
// down-counting phase timer for the port controller
// assumes load values of at least one cycle
`timescale 1ns/1ns
module dprc_timer
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       load,
    input  wire logic [3:0] load_val,
    output logic            done
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = load_val;
        else if (cnt_r != 4'h0)
            cnt_nxt = cnt_r - 4'h1;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_r <= 4'h0;
        else
            cnt_r <= cnt_nxt;
    end

    // pure count decode: folding load in here loops through the sequencer
    assign done = (cnt_r == 4'h1);

endmodule : dprc_timer

// ===== pkg/dprc_defs.svh
// constants for the dual-port ram port controller
// assumes one 125 MHz core clock; times are in ns and rounded up to cycles
`ifndef DPRC_DEFS_SVH
`define DPRC_DEFS_SVH

`define DPRC_ADDR_W      13
`define DPRC_DATA_W      8
`define DPRC_MBOX_LEFT   13'h1ffe
`define DPRC_MBOX_RIGHT  13'h1fff
`define DPRC_SEM_COUNT   4'h8
`define DPRC_SEM_IDX_W   3

`define DPRC_CLK_NS      8
`define DPRC_T_BSY_NS    30
`define DPRC_T_ACC_NS    55
`define DPRC_T_REC_NS    10
`define DPRC_SYNC_CYC    2

`define DPRC_CYC(ns)     (((ns) + `DPRC_CLK_NS - 1) / `DPRC_CLK_NS)
`define DPRC_BSY_CYC     `DPRC_CYC(`DPRC_T_BSY_NS)
`define DPRC_ACC_CYC     (`DPRC_CYC(`DPRC_T_ACC_NS) + `DPRC_SYNC_CYC)
`define DPRC_REC_CYC     `DPRC_CYC(`DPRC_T_REC_NS)

`endif

// ===== pkg/dprc_pkg.sv
// types shared by the port controller files
// assumes nothing beyond the defines header
package dprc_pkg;

    typedef enum logic [3:0] {
        DPRC_ST_IDLE   = 4'b0001,
        DPRC_ST_SETUP  = 4'b0010,
        DPRC_ST_STROBE = 4'b0100,
        DPRC_ST_RECOV  = 4'b1000
    } dprc_state_t;

    typedef enum logic [1:0] {
        DPRC_OP_RD     = 2'h0,
        DPRC_OP_WR     = 2'h1,
        DPRC_OP_SEM_RD = 2'h2,
        DPRC_OP_SEM_WR = 2'h3
    } dprc_op_t;

endpackage : dprc_pkg

// ===== sim/dprc_ram_model.sv
// behavioural dual-port ram facing the left port controller
// assumes the bench drives the right port pins directly
`timescale 1ns/1ns
module dprc_ram_model
(
    input  wire logic [12:0] l_addr,
    input  wire logic        l_ce_n,
    input  wire logic        semaphore_select_n,
    input  wire logic        l_rw_n,
    input  wire logic        l_oe_n,
    input  wire logic [7:0]  l_din,
    output logic      [7:0]  l_dout,
    input  wire logic        l_busy_pin_n,
    output logic             l_busy_n,
    output logic             left_mailbox_irq_n,
    output logic             right_mailbox_irq_n,
    input  wire logic        ms,
    input  wire logic [12:0] r_addr,
    input  wire logic        r_ce_n,
    input  wire logic        r_lock_n,
    input  wire logic        r_rw_n,
    input  wire logic        r_oe_n,
    input  wire logic [7:0]  r_din,
    output logic      [7:0]  r_dout
);
    // ------------------------------------------------------------
    // storage, flags and arbitration
    // ------------------------------------------------------------
    logic [7:0] mem [0:8191];
    logic [7:0] req_l   = 8'h00;
    logic [7:0] req_r   = 8'hff;
    logic [7:0] own_l   = 8'hff;
    logic [7:0] own_r   = 8'h00;
    logic [7:0] l_last  = 8'h00;
    logic       l_latch = 1'b0;
    logic       r_first = 1'b0;
    wire        l_lk_oe = semaphore_select_n | l_oe_n;
    wire        l_inh   = ms ? !l_busy_n : !l_busy_pin_n;

    // flags start raised: power-up state is not defined
    initial
    begin
        left_mailbox_irq_n = 1'b0;
        right_mailbox_irq_n = 1'b0;
    end

    // only the left port is flagged, when it selects after the right, so never both low
    always @(negedge l_ce_n)
        r_first = !r_ce_n;
    assign l_busy_n = !(ms && !l_ce_n && !r_ce_n && r_first
                        && l_addr == r_addr);

    // lock logic touches no memory
    task automatic lock_upd(input bit left, input int i, input bit b);
        if (left)
            req_l[i] = b;
        else
            req_r[i] = b;
        if (own_l[i] && req_l[i])
            {own_l[i], own_r[i]} = {1'b0, !req_r[i]};
        else if (own_r[i] && req_r[i])
            {own_r[i], own_l[i]} = {1'b0, !req_l[i]};
        else if (!own_l[i] && !own_r[i])
            {own_l[i], own_r[i]} = {!req_l[i], req_l[i] && !req_r[i]};
    endtask : lock_upd

    always @*
    begin
        if (!l_ce_n && !l_rw_n && !l_inh)
        begin
            mem[l_addr] = l_din;
            if (l_addr == 13'h1fff)
                right_mailbox_irq_n = 1'b0;
        end
        if (!l_ce_n && !l_oe_n && l_addr == 13'h1ffe)
            left_mailbox_irq_n = 1'b1;
        if (!r_ce_n && !r_rw_n)
        begin
            mem[r_addr] = r_din;
            if (r_addr == 13'h1ffe)
                left_mailbox_irq_n = 1'b0;
        end
        if (!r_ce_n && !r_oe_n && r_rw_n && r_addr == 13'h1fff)
            right_mailbox_irq_n = 1'b1;
        if (!semaphore_select_n && !l_rw_n)
            lock_upd(1'b1, l_addr[2:0], l_din[0]);
        if (!r_lock_n && !r_rw_n)
            lock_upd(1'b0, r_addr[2:0], r_din[0]);
    end

    // ------------------------------------------------------------
    // read paths
    // ------------------------------------------------------------
    always @(negedge l_lk_oe)
        l_latch = !own_l[l_addr[2:0]];

    always @*
    begin
        if (!l_ce_n && !l_oe_n && l_rw_n)
        begin
            l_dout = mem[l_addr];
            l_last = l_dout;
        end
        else if (!l_lk_oe && l_rw_n)
        begin
            l_dout = {8{l_latch}};
            l_last = l_dout;
        end
        else
            l_dout = ~l_last;
    end

    // right side never waits on the left
    assign r_dout = r_lock_n ? mem[r_addr] : {8{!own_r[r_addr[2:0]]}};
endmodule : dprc_ram_model

// ===== sim/tb_dual_port_ram_arbitration_mailbox.sv
// self-checking bench: left port controller against a behavioural ram
// assumes the bench plays the right-hand processor on the pins
`timescale 1ns/1ns
module tb_dual_port_ram_arbitration_mailbox
import dprc_pkg::*;
;
    // ------------------------------------------------------------
    // wiring
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        req_valid = 1'b0;
    logic        write_inhibit = 1'b0;
    logic        master_mode = 1'b1;
    logic [1:0]  req_op = 2'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [12:0] r_addr = 13'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic [7:0]  r_din = 8'h00;
    logic        r_ce_n = 1'b1;
    logic        r_lock_n = 1'b1;
    logic        r_rw_n = 1'b1;
    logic        r_oe_n = 1'b1;
    logic        req_ready, resp_valid, resp_collided, init_done;
    logic        mailbox_irq, mem_select_n, semaphore_select_n, rw_n;
    logic        oe_n, data_oe, busy_out_n, busy_oe, busy_l_n;
    logic        l_irq_n, r_irq_n, col;
    logic [12:0] mem_addr, a;
    logic [7:0]  resp_rdata, data_out, m_dout, r_dout, d, rd, seen;
    logic [12:0] addrs [10];
    logic [7:0]  ref_mem [0:8191];
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          i, n;
    wire  [7:0]  dq = data_oe ? data_out : m_dout;
    wire         busy_pin = busy_oe ? busy_out_n : busy_l_n;

    dprc_port_ctrl #(.PORT_IS_LEFT(1'b1)) dprc_port_ctrl_i
    (
        .core_clk, .reset_n, .req_valid, .req_ready, .req_op, .req_addr,
        .req_wdata, .resp_valid, .resp_rdata, .resp_collided, .init_done,
        .mailbox_irq, .write_inhibit, .master_mode, .mem_addr,
        .mem_select_n, .semaphore_select_n, .rw_n, .oe_n, .data_out,
        .data_oe, .data_in(dq), .busy_in_n(busy_pin), .busy_out_n,
        .busy_oe, .port_mailbox_irq_n(l_irq_n)
    );

    dprc_ram_model dprc_ram_model_i
    (
        .l_addr(mem_addr), .l_ce_n(mem_select_n), .semaphore_select_n,
        .l_rw_n(rw_n), .l_oe_n(oe_n), .l_din(dq), .l_dout(m_dout),
        .l_busy_pin_n(busy_pin), .l_busy_n(busy_l_n),
        .left_mailbox_irq_n(l_irq_n), .right_mailbox_irq_n(r_irq_n),
        .ms(master_mode), .r_addr, .r_ce_n, .r_lock_n, .r_rw_n, .r_oe_n,
        .r_din, .r_dout
    );

    // ------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------
    always #4 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] spread(input logic b);
        return {8{b}};
    endfunction : spread

    task automatic req(input logic [1:0] op, input logic [12:0] ad,
                       input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge core_clk);
        #1;
        {req_op, req_addr, req_wdata} = {op, ad, wd};
        req_valid = 1'b1;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (req_ready !== 1'b1 && k < 500);
        #1;
        req_valid = 1'b0;
        do
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        while (resp_valid !== 1'b1 && k < 3000);
        if (k >= 3000)
            err_total++;
        rd = resp_rdata;
        col = resp_collided;
    endtask : req

    task automatic rport(input logic lk, input logic wr,
                         input logic [12:0] ad, input logic [7:0] wd);
        @(posedge core_clk);
        #1;
        {r_addr, r_din} = {ad, wd};
        {r_ce_n, r_lock_n, r_rw_n, r_oe_n} = {lk, !lk, !wr, wr};
        repeat (3) @(posedge core_clk);
        #1;
        seen = r_dout;
        {r_ce_n, r_lock_n, r_rw_n, r_oe_n} = 4'hf;
    endtask : rport

    task automatic wait_irq(input logic v);
        int k;
        k = 0;
        while (mailbox_irq !== v && k < 20)
        begin
            @(posedge core_clk);
            k++;
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h3d00ce59));
        repeat (16) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("init_done", 8'h01, init_done);
        chk("mailbox_irq", 8'h00, mailbox_irq);
        addrs[0] = 13'h0000;
        addrs[1] = 13'h1ffd;
        for (i = 2; i < 10; i++)
            addrs[i] = 13'($urandom_range(32'h1ffd));
        for (i = 0; i < 10; i++)
        begin
            d = 8'($urandom);
            req(DPRC_OP_WR, addrs[i], d);
            ref_mem[addrs[i]] = d;
        end
        for (i = 0; i < 10; i++)
        begin
            req(DPRC_OP_RD, addrs[i], 8'h00);
            chk("ram read", ref_mem[addrs[i]], rd);
            chk("collided", 8'h00, col);
        end
        rport(1'b0, 1'b0, 13'h1fff, 8'h00);
        req(DPRC_OP_WR, 13'h1fff, 8'ha5);
        chk("right flag", 8'h00, r_irq_n);
        rport(1'b0, 1'b0, 13'h1fff, 8'h00);
        chk("right mailbox", 8'ha5, seen);
        chk("right flag", 8'h01, r_irq_n);
        rport(1'b0, 1'b1, 13'h1ffe, 8'h3c);
        wait_irq(1'b1);
        chk("mailbox_irq", 8'h01, mailbox_irq);
        req(DPRC_OP_RD, 13'h1ffe, 8'h00);
        chk("left mailbox", 8'h3c, rd);
        wait_irq(1'b0);
        chk("mailbox_irq", 8'h00, mailbox_irq);
        for (i = 0; i < 8; i++)
        begin
            a = {10'($urandom), 3'(i)};
            req(DPRC_OP_SEM_WR, a, 8'hfe);
            req(DPRC_OP_SEM_RD, {~a[12:3], a[2:0]}, 8'h00);
            chk("left lock", spread(1'b0), rd);
            rport(1'b1, 1'b0, a, 8'h00);
            chk("right lock", spread(1'b1), seen);
            rport(1'b1, 1'b1, a, 8'h00);
            req(DPRC_OP_SEM_WR, a, 8'h01);
            req(DPRC_OP_SEM_RD, a, 8'h00);
            chk("left lock", spread(1'b1), rd);
            rport(1'b1, 1'b0, a, 8'h00);
            chk("right lock", spread(1'b0), seen);
            rport(1'b1, 1'b1, a, 8'h01);
        end
        // right reads word 0 first, left write must wait
        {r_addr, r_ce_n, r_oe_n} = {13'h0000, 2'h0};
        fork
            req(DPRC_OP_WR, 13'h0000, 8'h77);
            begin
                repeat (60) @(posedge core_clk);
                #1;
                chk("held word", ref_mem[13'h0000], r_dout);
                {r_ce_n, r_oe_n} = 2'h3;
            end
        join
        chk("collided", 8'h01, col);
        req(DPRC_OP_RD, 13'h0000, 8'h00);
        chk("ram read", 8'h77, rd);
        {r_ce_n, r_oe_n} = 2'h0;
        req(DPRC_OP_SEM_RD, 13'h0000, 8'h00);
        chk("collided", 8'h00, col);
        chk("left lock", spread(1'b1), rd);
        {r_ce_n, r_oe_n} = 2'h3;
        master_mode = 1'b0;
        write_inhibit = 1'b1;
        req(DPRC_OP_WR, 13'h0000, 8'h11);
        chk("busy drive", 8'h01, busy_oe);
        chk("busy level", 8'h00, busy_out_n);
        req(DPRC_OP_RD, 13'h0000, 8'h00);
        chk("ram read", 8'h77, rd);
        write_inhibit = 1'b0;
        req(DPRC_OP_WR, 13'h0000, 8'h11);
        req(DPRC_OP_RD, 13'h0000, 8'h00);
        chk("ram read", 8'h11, rd);
        chk("busy level", 8'h01, busy_out_n);
        give_verdict();
    end
endmodule : tb_dual_port_ram_arbitration_mailbox
